// file: shared/mosp_defs.vh
// Constants for the multi-function output select and polarity block.
// Assumes inclusion by bare name from design files; definitions only.
`ifndef MOSP_DEFS_VH
`define MOSP_DEFS_VH

// Register addresses on the documented parameter port.
`define MOSP_ADDR_COMM_WORD    16'h2640
`define MOSP_ADDR_POL_MASK     16'h0213
`define MOSP_ADDR_CAN_OBJ      16'h2026
`define MOSP_ADDR_FUNC_RELAY   16'h020D
`define MOSP_ADDR_FUNC_ONE     16'h0210
`define MOSP_ADDR_FUNC_TWO     16'h0211
`define MOSP_ADDR_AN_HIGH      16'h032D
`define MOSP_ADDR_AN_LOW       16'h032E
`define MOSP_ADDR_TQ3_LEVEL    16'h0E4B
`define MOSP_ADDR_TQ3_TIME     16'h0E4C
`define MOSP_ADDR_TQ4_LEVEL    16'h0E4E
`define MOSP_ADDR_TQ4_TIME     16'h0E4F
`define MOSP_ADDR_STATUS       16'h0233

// Bit positions of the three terminals in every control word.
`define MOSP_BIT_RELAY         0
`define MOSP_BIT_ONE           3
`define MOSP_BIT_TWO           4

// Function codes.
`define MOSP_FN_CANOPEN        8'h32
`define MOSP_FN_COMM_CARD      8'h33
`define MOSP_FN_SAFE_A         8'h42
`define MOSP_FN_ANALOG         8'h43
`define MOSP_FN_SAFE_B         8'h44
`define MOSP_FN_TORQUE3        8'h49
`define MOSP_FN_TORQUE4        8'h4A

// Reset values.
`define MOSP_RST_POL_MASK      16'h0000
`define MOSP_RST_COMM_WORD     16'h0000
`define MOSP_RST_CAN_OBJ       16'h0001
`define MOSP_RST_FUNC          8'h00
`define MOSP_RST_AN_HIGH       16'h8000
`define MOSP_RST_AN_LOW        16'h1999
`define MOSP_RST_TQ_LEVEL      16'hFFFF
`define MOSP_RST_TQ_TIME       16'h0064

// Detection time unit in ns and derived clock cycles per unit at 25 MHz.
`define MOSP_TQ_UNIT_NS        1000000
`define MOSP_CLK_PERIOD_NS     40
`define MOSP_TQ_UNIT_CYC       (`MOSP_TQ_UNIT_NS / `MOSP_CLK_PERIOD_NS)

`endif

// file: verilog/mosp_torque_det.v
// Over-torque detector: level compare held for a time in millisecond units.
// Assumes torque and settings are synchronous to the clock.
`timescale 1ns/100ps
`include "mosp_defs.vh"

module mosp_torque_det #(
    parameter integer UNIT_CYC = `MOSP_TQ_UNIT_CYC
) (
    // Clock and reset.
    input  wire        clk_in,
    input  wire        reset_in,
    // Measurement and settings.
    input  wire [15:0] torque_in,
    input  wire [15:0] level_in,
    input  wire [15:0] time_in,
    // Result.
    output reg         detect_out
);

reg  [31:0] tick_q;
reg  [15:0] units_q;
wire        over = torque_in > level_in;
wire        tick_end = (tick_q == UNIT_CYC - 1);

always @(posedge clk_in) begin
    if (reset_in || !over) begin
        tick_q     <= 32'h0000_0000;
        units_q    <= 16'h0000;
        detect_out <= 1'b0;
    end else begin
        tick_q <= tick_end ? 32'h0000_0000 : tick_q + 32'h0000_0001;
        if (tick_end && units_q != 16'hFFFF) begin
            units_q <= units_q + 16'h0001;
        end
        if (units_q >= time_in && tick_end) begin
            detect_out <= 1'b1;
        end
    end
end

endmodule

// file: verilog/mosp_top.v
// Multi-function output selection and polarity for relay and two open-collector outputs.
// Assumes a synchronous parameter write port on the same clock and a combinational read port; status pins are async.
`timescale 1ns/100ps
`include "mosp_defs.vh"

// Function
// [RULE1] CANopen function drives relay, one, two from object bits 0, 3, 4.
// [RULE2] Comm-card function drives relay, one, two from bits 0, 3, 4 of a writable word.
// [RULE3] Safety logic A keeps the terminal open normally and closed in safe-torque-off or fault.
// [RULE4] Safety logic B keeps the terminal closed normally and open in safe-torque-off or fault.
// [RULE5] Analog function turns on above a high threshold, default half scale.
// [RULE6] Analog function turns off below a low threshold, default ten percent, holding between.
// [RULE7] Over-torque three asserts when torque exceeds its level for longer than its time.
// [RULE8] Over-torque four does the same with its own level and time.
// [RULE9] A 16-bit polarity mask resets to zero; bits 0, 3, 4 govern the terminals.
// [RULE10] A mask bit of one inverts its terminal, zero passes it directly.
// [RULE11] Inversion is applied after function selection for every source.
module mosp_top #(
    parameter integer UNIT_CYC = `MOSP_TQ_UNIT_CYC
) (
    // Clock and reset.
    input  wire        CLK_IN,
    input  wire        RESET_IN,
    // Parameter port.
    input  wire        REG_WR_IN,
    input  wire [15:0] REG_ADDR_IN,
    input  wire [15:0] REG_WDATA_IN,
    output reg  [15:0] REG_RDATA_OUT,
    // Drive state inputs.
    input  wire        SAFE_TORQUE_OFF_STATE_IN,
    input  wire        SAFETY_FAULT_STATES_IN,
    input  wire [15:0] ANALOG_LEVEL_IN,
    input  wire [15:0] TORQUE_IN,
    // Terminals.
    output reg         RELAY_OUTPUT_OUT,
    output reg         OPEN_COLLECTOR_OUT_ONE_OUT,
    output reg         OPEN_COLLECTOR_OUT_TWO_OUT
);

////////////////////////////////////////////////////////////////////////////////
reg  [15:0] comm_word_q;
reg  [15:0] pol_mask_q;
reg  [15:0] can_obj_q;
reg  [7:0]  fn_q [0:2];
reg  [15:0] an_high_q;
reg  [15:0] an_low_q;
reg  [15:0] tq3_lvl_q;
reg  [15:0] tq3_time_q;
reg  [15:0] tq4_lvl_q;
reg  [15:0] tq4_time_q;
reg  [1:0]  sto_sync_q;
reg  [1:0]  flt_sync_q;
reg  [15:0] an_q;
reg         an_state_q;
reg  [2:0]  term_d;
wire        tq3_det;
wire        tq4_det;
wire        safety_active = sto_sync_q[1] | flt_sync_q[1];

function integer term_bit;
    input integer idx;
    begin
        term_bit = (idx == 0) ? `MOSP_BIT_RELAY : (idx == 1) ? `MOSP_BIT_ONE : `MOSP_BIT_TWO;
    end
endfunction

////////////////////////////////////////////////////////////////////////////////
always @(posedge CLK_IN) begin
    if (RESET_IN) begin
        comm_word_q <= `MOSP_RST_COMM_WORD;
        pol_mask_q  <= `MOSP_RST_POL_MASK;                          // [RULE9]
        can_obj_q   <= `MOSP_RST_CAN_OBJ;
        fn_q[0]     <= `MOSP_RST_FUNC;
        fn_q[1]     <= `MOSP_RST_FUNC;
        fn_q[2]     <= `MOSP_RST_FUNC;
        an_high_q   <= `MOSP_RST_AN_HIGH;                           // [RULE5]
        an_low_q    <= `MOSP_RST_AN_LOW;                            // [RULE6]
        tq3_lvl_q   <= `MOSP_RST_TQ_LEVEL;
        tq3_time_q  <= `MOSP_RST_TQ_TIME;
        tq4_lvl_q   <= `MOSP_RST_TQ_LEVEL;
        tq4_time_q  <= `MOSP_RST_TQ_TIME;
    end else if (REG_WR_IN) begin
        case (REG_ADDR_IN)
            `MOSP_ADDR_COMM_WORD: begin
                comm_word_q <= REG_WDATA_IN;                        // [RULE2]
            end
            `MOSP_ADDR_POL_MASK: begin
                pol_mask_q <= REG_WDATA_IN & 16'hFFF9;              // [RULE9]
            end
            `MOSP_ADDR_CAN_OBJ: begin
                can_obj_q <= REG_WDATA_IN;                          // [RULE1]
            end
            `MOSP_ADDR_FUNC_RELAY: begin
                fn_q[0] <= REG_WDATA_IN[7:0];
            end
            `MOSP_ADDR_FUNC_ONE: begin
                fn_q[1] <= REG_WDATA_IN[7:0];
            end
            `MOSP_ADDR_FUNC_TWO: begin
                fn_q[2] <= REG_WDATA_IN[7:0];
            end
            `MOSP_ADDR_AN_HIGH: begin
                an_high_q <= REG_WDATA_IN;
            end
            `MOSP_ADDR_AN_LOW: begin
                an_low_q <= REG_WDATA_IN;
            end
            `MOSP_ADDR_TQ3_LEVEL: begin
                tq3_lvl_q <= REG_WDATA_IN;
            end
            `MOSP_ADDR_TQ3_TIME: begin
                tq3_time_q <= REG_WDATA_IN;
            end
            `MOSP_ADDR_TQ4_LEVEL: begin
                tq4_lvl_q <= REG_WDATA_IN;
            end
            `MOSP_ADDR_TQ4_TIME: begin
                tq4_time_q <= REG_WDATA_IN;
            end
            default: begin
            end
        endcase
    end
end

////////////////////////////////////////////////////////////////////////////////
always @(posedge CLK_IN) begin
    if (RESET_IN) begin
        sto_sync_q <= 2'b00;
        flt_sync_q <= 2'b00;
        an_q       <= 16'h0000;
        an_state_q <= 1'b0;
    end else begin
        sto_sync_q <= {sto_sync_q[0], SAFE_TORQUE_OFF_STATE_IN};
        flt_sync_q <= {flt_sync_q[0], SAFETY_FAULT_STATES_IN};
        an_q       <= ANALOG_LEVEL_IN;
        if (an_q > an_high_q) begin
            an_state_q <= 1'b1;                                     // [RULE5]
        end else if (an_q < an_low_q) begin
            an_state_q <= 1'b0;                                     // [RULE6]
        end
    end
end

mosp_torque_det #(.UNIT_CYC(UNIT_CYC)) u_tq3 (
    .clk_in     (CLK_IN),
    .reset_in   (RESET_IN),
    .torque_in  (TORQUE_IN),
    .level_in   (tq3_lvl_q),
    .time_in    (tq3_time_q),
    .detect_out (tq3_det)                                           // [RULE7]
);

mosp_torque_det #(.UNIT_CYC(UNIT_CYC)) u_tq4 (
    .clk_in     (CLK_IN),
    .reset_in   (RESET_IN),
    .torque_in  (TORQUE_IN),
    .level_in   (tq4_lvl_q),
    .time_in    (tq4_time_q),
    .detect_out (tq4_det)                                           // [RULE8]
);

////////////////////////////////////////////////////////////////////////////////
integer i;
reg     sel;
always @* begin
    term_d = 3'b000;
    sel    = 1'b0;
    for (i = 0; i < 3; i = i + 1) begin
        case (fn_q[i])
            `MOSP_FN_CANOPEN:   sel = can_obj_q[term_bit(i)];       // [RULE1]
            `MOSP_FN_COMM_CARD: sel = comm_word_q[term_bit(i)];     // [RULE2]
            `MOSP_FN_SAFE_A:    sel = safety_active;                // [RULE3]
            `MOSP_FN_SAFE_B:    sel = ~safety_active;               // [RULE4]
            `MOSP_FN_ANALOG:    sel = an_state_q;
            `MOSP_FN_TORQUE3:   sel = tq3_det;
            `MOSP_FN_TORQUE4:   sel = tq4_det;
            default:            sel = 1'b0;
        endcase
        term_d[i] = sel ^ pol_mask_q[term_bit(i)];                  // [RULE10] [RULE11]
    end
end

always @(posedge CLK_IN) begin
    if (RESET_IN) begin
        RELAY_OUTPUT_OUT           <= 1'b0;
        OPEN_COLLECTOR_OUT_ONE_OUT <= 1'b0;
        OPEN_COLLECTOR_OUT_TWO_OUT <= 1'b0;
    end else begin
        RELAY_OUTPUT_OUT           <= term_d[0];
        OPEN_COLLECTOR_OUT_ONE_OUT <= term_d[1];
        OPEN_COLLECTOR_OUT_TWO_OUT <= term_d[2];
    end
end

////////////////////////////////////////////////////////////////////////////////
always @* begin
    case (REG_ADDR_IN)
        `MOSP_ADDR_COMM_WORD:  REG_RDATA_OUT = comm_word_q;
        `MOSP_ADDR_POL_MASK:   REG_RDATA_OUT = pol_mask_q;
        `MOSP_ADDR_CAN_OBJ:    REG_RDATA_OUT = can_obj_q;
        `MOSP_ADDR_FUNC_RELAY: REG_RDATA_OUT = {8'h00, fn_q[0]};
        `MOSP_ADDR_FUNC_ONE:   REG_RDATA_OUT = {8'h00, fn_q[1]};
        `MOSP_ADDR_FUNC_TWO:   REG_RDATA_OUT = {8'h00, fn_q[2]};
        `MOSP_ADDR_AN_HIGH:    REG_RDATA_OUT = an_high_q;
        `MOSP_ADDR_AN_LOW:     REG_RDATA_OUT = an_low_q;
        `MOSP_ADDR_TQ3_LEVEL:  REG_RDATA_OUT = tq3_lvl_q;
        `MOSP_ADDR_TQ3_TIME:   REG_RDATA_OUT = tq3_time_q;
        `MOSP_ADDR_TQ4_LEVEL:  REG_RDATA_OUT = tq4_lvl_q;
        `MOSP_ADDR_TQ4_TIME:   REG_RDATA_OUT = tq4_time_q;
        `MOSP_ADDR_STATUS:     REG_RDATA_OUT = {11'h000, OPEN_COLLECTOR_OUT_TWO_OUT,
                                                OPEN_COLLECTOR_OUT_ONE_OUT, 2'b00,
                                                RELAY_OUTPUT_OUT};
        default:               REG_RDATA_OUT = 16'h0000;
    endcase
end

endmodule

// file: tb/mosp_fb_master.sv
// Fieldbus master model that owns the parameter write port.
// Assumes the block takes a write at a rising edge with the strobe high.
`timescale 1ns/100ps
module mosp_fb_master (
    // Clock and read data.
    input  wire        clk_in,
    input  wire [15:0] rdata_in,
    // Parameter port.
    output reg         wr_out,
    output reg  [15:0] addr_out,
    output reg  [15:0] wdata_out
);
    initial begin
        wr_out = 1'b0;
        addr_out = 16'h0000;
        wdata_out = 16'h0000;
    end
    // Holds a write over one rising edge, then scrambles the released data lines.
    task wr(input [15:0] a, input [15:0] d);
        begin
            @(negedge clk_in);
            wr_out = 1'b1;
            addr_out = a;
            wdata_out = d;
            @(negedge clk_in);
            wr_out = 1'b0;
            wdata_out = ~d;
        end
    endtask
    task rd(input [15:0] a, output [15:0] q);
        begin
            @(negedge clk_in);
            addr_out = a;
            @(posedge clk_in);
            q = rdata_in;
        end
    endtask
endmodule

// file: tb/mosp_chk_sva.sv
// Checker for terminal selection and polarity.
// Assumes a bind to mosp_top; registers are shadowed from the write port.
`timescale 1ns/100ps
`include "mosp_defs.vh"
module mosp_chk (
    input wire        CLK_IN,
    input wire        RESET_IN,
    input wire        REG_WR_IN,
    input wire [15:0] REG_ADDR_IN,
    input wire [15:0] REG_WDATA_IN,
    input wire [15:0] REG_RDATA_OUT,
    input wire        SAFE_TORQUE_OFF_STATE_IN,
    input wire        SAFETY_FAULT_STATES_IN,
    input wire [15:0] ANALOG_LEVEL_IN,
    input wire        RELAY_OUTPUT_OUT,
    input wire        OPEN_COLLECTOR_OUT_ONE_OUT
);
    reg [7:0]  fr_q, fo_q;
    reg [4:0]  mk_q, cm_q, cn_q;
    reg [15:0] hi_q, lo_q;
    reg        mask_clean_q;
    wire       an_sel = fr_q == `MOSP_FN_ANALOG && !mk_q[0];
    always @(posedge CLK_IN) begin
        if (RESET_IN) begin
            {fr_q, fo_q, mk_q, cm_q} <= 26'h000_0000;
            cn_q <= 5'h01;
            mask_clean_q <= 1'b1;
            hi_q <= `MOSP_RST_AN_HIGH;
            lo_q <= `MOSP_RST_AN_LOW;
        end else if (REG_WR_IN) begin
            case (REG_ADDR_IN)
                `MOSP_ADDR_FUNC_RELAY: fr_q <= REG_WDATA_IN[7:0];
                `MOSP_ADDR_FUNC_ONE:   fo_q <= REG_WDATA_IN[7:0];
                `MOSP_ADDR_POL_MASK: begin
                    mk_q <= REG_WDATA_IN[4:0];
                    mask_clean_q <= 1'b0;
                end
                `MOSP_ADDR_COMM_WORD:  cm_q <= REG_WDATA_IN[4:0];
                `MOSP_ADDR_CAN_OBJ:    cn_q <= REG_WDATA_IN[4:0];
                `MOSP_ADDR_AN_HIGH:    hi_q <= REG_WDATA_IN;
                `MOSP_ADDR_AN_LOW:     lo_q <= REG_WDATA_IN;
                default: ;
            endcase
        end
    end
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (RESET_IN);
    sequence s_sto_a;
        (SAFE_TORQUE_OFF_STATE_IN && fr_q == `MOSP_FN_SAFE_A && !mk_q[0]) [*4];
    endsequence
    sequence s_norm_b;
        (!SAFE_TORQUE_OFF_STATE_IN && !SAFETY_FAULT_STATES_IN && fo_q == `MOSP_FN_SAFE_B
            && !mk_q[3]) [*4];
    endsequence
    comm_relay_a: assert property (fr_q == `MOSP_FN_COMM_CARD |=>
        RELAY_OUTPUT_OUT == $past(cm_q[0] ^ mk_q[0])) else $error("relay off comm word");
    can_one_a: assert property (fo_q == `MOSP_FN_CANOPEN |=>
        OPEN_COLLECTOR_OUT_ONE_OUT == $past(cn_q[3] ^ mk_q[3])) else $error("one off object");
    safe_a_a: assert property (s_sto_a |-> RELAY_OUTPUT_OUT)
        else $error("logic A open in stop");
    safe_b_a: assert property (s_norm_b |-> OPEN_COLLECTOR_OUT_ONE_OUT)
        else $error("logic B open in normal");
    analog_set_a: assert property ((an_sel && ANALOG_LEVEL_IN > hi_q) [*4]
        |-> RELAY_OUTPUT_OUT) else $error("analog not set");
    analog_clear_a: assert property ((an_sel && ANALOG_LEVEL_IN < lo_q) [*4]
        |-> !RELAY_OUTPUT_OUT) else $error("analog not cleared");
    analog_hold_a: assert property ((an_sel && ANALOG_LEVEL_IN <= hi_q
        && ANALOG_LEVEL_IN >= lo_q) [*5] |-> $stable(RELAY_OUTPUT_OUT)) else $error("no hold");
    mask_bits_a: assert property (REG_ADDR_IN == `MOSP_ADDR_POL_MASK |->
        REG_RDATA_OUT[2:1] == 2'h0) else $error("reserved mask bits set");
    mask_reset_a: assert property (mask_clean_q && REG_ADDR_IN == `MOSP_ADDR_POL_MASK
        |-> REG_RDATA_OUT == 16'h0000) else $error("mask not zero after reset");
endmodule

// file: tb/mosp_testbench.sv
// Self-checking bench for terminal selection and polarity.
// Assumes mosp_top with a short torque time unit and the fieldbus model.
`timescale 1ns/100ps
`include "mosp_defs.vh"
module testbench;
    reg         CLK_IN, RESET_IN, safe_torque_off_state, flt;
    reg  [15:0] ana, tq, rd_q;
    wire        wr, relay, one, two;
    wire [15:0] addr, wdata, rdata;
    integer     miscompares, check_count, cycles;
    initial CLK_IN = 1'b0;
    always #20 CLK_IN = ~CLK_IN;
    mosp_top #(.UNIT_CYC(4)) uut (.CLK_IN(CLK_IN), .RESET_IN(RESET_IN), .REG_WR_IN(wr),
        .REG_ADDR_IN(addr), .REG_WDATA_IN(wdata), .REG_RDATA_OUT(rdata),
        .SAFE_TORQUE_OFF_STATE_IN(safe_torque_off_state), .SAFETY_FAULT_STATES_IN(flt), .ANALOG_LEVEL_IN(ana),
        .TORQUE_IN(tq), .RELAY_OUTPUT_OUT(relay), .OPEN_COLLECTOR_OUT_ONE_OUT(one),
        .OPEN_COLLECTOR_OUT_TWO_OUT(two));
    mosp_fb_master fb (.clk_in(CLK_IN), .rdata_in(rdata), .wr_out(wr), .addr_out(addr),
        .wdata_out(wdata));
    ////////////////////////////////////////////////////////////////////////////////
    task close_out;
        begin
            $display("checks %0d mismatches %0d", check_count, miscompares);
            if (miscompares == 0 && check_count > 0)
                $display("TB: PASS");
            else
                $display("TB: FAIL");
            $finish;
        end
    endtask
    task chk(input [15:0] got, input [15:0] exp);
        begin
            check_count = check_count + 1;
            if (got !== exp) begin
                miscompares = miscompares + 1;
                $display("mismatch at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task term(input [2:0] exp);
        chk({13'h0000, two, one, relay}, {13'h0000, exp});
    endtask
    task rchk(input [15:0] a, input [15:0] exp);
        begin
            fb.rd(a, rd_q);
            chk(rd_q, exp);
        end
    endtask
    task w(input [15:0] a, input [15:0] d);
        fb.wr(a, d);
    endtask
    task cyc(input integer n);
        repeat (n) @(negedge CLK_IN);
    endtask
    always @(posedge CLK_IN) begin
        cycles = cycles + 1;
        if (cycles == 3000) begin
            miscompares = miscompares + 1;
            close_out;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        {miscompares, check_count, cycles} = 96'h0;
        {RESET_IN, safe_torque_off_state, flt, ana, tq} = 35'h4_0000_0000;
        cyc(6);
        RESET_IN = 1'b0;
        term(3'h0);
        rchk(`MOSP_ADDR_POL_MASK, 16'h0000);
        rchk(16'h1234, 16'h0000);
        w(`MOSP_ADDR_POL_MASK, 16'hFFFF);
        rchk(`MOSP_ADDR_POL_MASK, 16'hFFF9);
        $display("test reset done");
        w(`MOSP_ADDR_FUNC_RELAY, 16'h0033);
        w(`MOSP_ADDR_FUNC_ONE, 16'h0033);
        w(`MOSP_ADDR_FUNC_TWO, 16'h0033);
        w(`MOSP_ADDR_POL_MASK, 16'h0000);
        w(`MOSP_ADDR_COMM_WORD, 16'h0019);
        cyc(1);
        term(3'h7);
        w(`MOSP_ADDR_COMM_WORD, 16'h0008);
        cyc(1);
        term(3'h2);
        w(`MOSP_ADDR_POL_MASK, 16'h0019);
        cyc(1);
        term(3'h5);
        w(`MOSP_ADDR_COMM_WORD, 16'h0000);
        cyc(1);
        term(3'h7);
        rchk(`MOSP_ADDR_STATUS, 16'h0019);
        $display("test comm card done");
        w(`MOSP_ADDR_POL_MASK, 16'h0000);
        w(`MOSP_ADDR_FUNC_RELAY, 16'h0032);
        w(`MOSP_ADDR_FUNC_ONE, 16'h0032);
        w(`MOSP_ADDR_FUNC_TWO, 16'h0032);
        cyc(1);
        term(3'h1);
        w(`MOSP_ADDR_CAN_OBJ, 16'h0018);
        cyc(1);
        term(3'h6);
        w(`MOSP_ADDR_CAN_OBJ, 16'h0000);
        w(`MOSP_ADDR_FUNC_RELAY, 16'h0042);
        w(`MOSP_ADDR_FUNC_ONE, 16'h0044);
        cyc(4);
        term(3'h2);
        safe_torque_off_state = 1'b1;
        cyc(4);
        term(3'h1);
        safe_torque_off_state = 1'b0;
        flt = 1'b1;
        cyc(4);
        term(3'h1);
        flt = 1'b0;
        $display("test safety done");
        w(`MOSP_ADDR_FUNC_RELAY, 16'h0043);
        ana = 16'h8001;
        cyc(4);
        term(3'h3);
        ana = 16'h4000;
        cyc(4);
        term(3'h3);
        ana = 16'h1998;
        cyc(4);
        term(3'h2);
        ana = 16'h8000;
        cyc(4);
        term(3'h2);
        w(`MOSP_ADDR_AN_HIGH, 16'h7000);
        cyc(4);
        term(3'h3);
        ana = 16'h2000;
        w(`MOSP_ADDR_AN_LOW, 16'h3000);
        cyc(4);
        term(3'h2);
        w(`MOSP_ADDR_FUNC_ONE, 16'h0049);
        w(`MOSP_ADDR_FUNC_TWO, 16'h004A);
        w(`MOSP_ADDR_TQ3_LEVEL, 16'h0100);
        w(`MOSP_ADDR_TQ3_TIME, 16'h0002);
        w(`MOSP_ADDR_TQ4_LEVEL, 16'h0200);
        w(`MOSP_ADDR_TQ4_TIME, 16'h0003);
        tq = 16'h0150;
        cyc(4);
        term(3'h0);
        cyc(20);
        term(3'h2);
        tq = 16'h0100;
        cyc(2);
        term(3'h0);
        tq = 16'h0250;
        cyc(30);
        term(3'h6);
        $display("test analog torque done");
        w(`MOSP_ADDR_POL_MASK, 16'h0019);
        RESET_IN = 1'b1;
        cyc(2);
        RESET_IN = 1'b0;
        term(3'h0);
        rchk(`MOSP_ADDR_POL_MASK, 16'h0000);
        $display("test reset again done");
        close_out;
    end
endmodule
bind mosp_top mosp_chk u_chk (.CLK_IN(CLK_IN), .RESET_IN(RESET_IN), .REG_WR_IN(REG_WR_IN),
    .REG_ADDR_IN(REG_ADDR_IN), .REG_WDATA_IN(REG_WDATA_IN), .REG_RDATA_OUT(REG_RDATA_OUT),
    .SAFE_TORQUE_OFF_STATE_IN(SAFE_TORQUE_OFF_STATE_IN), .ANALOG_LEVEL_IN(ANALOG_LEVEL_IN),
    .SAFETY_FAULT_STATES_IN(SAFETY_FAULT_STATES_IN), .RELAY_OUTPUT_OUT(RELAY_OUTPUT_OUT),
    .OPEN_COLLECTOR_OUT_ONE_OUT(OPEN_COLLECTOR_OUT_ONE_OUT));
